// file: core/pipe_slot_ctrl.v
/*
 * Slot control for a five-stage in-order pipeline: fetch, decode,
 * execute, memory access, write-back/DSP. Stages advance together at
 * the end of each slot; a slot lasts for any data access plus the fetch that waits for it.
 * Assumes instruction and data memory on clock_i with request/ack
 * handshakes, and an external decoder that classifies id_word_o in
 * the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pipe_slot_regs.vh"

module pipe_slot_ctrl #(
  parameter IW = 16,
  parameter CW = 8
) (
  input  wire          clock_i,
  input  wire          rstn_i,
  input  wire          run_i,
  output reg           imem_req_o,
  input  wire          imem_ack_i,
  input  wire [IW-1:0] imem_rdata_i,
  output reg           dmem_req_o,
  output reg           dmem_we_o,
  input  wire          dmem_ack_i,
  input  wire          dec_ma_i,
  input  wire          dec_load_i,
  input  wire          dec_store_i,
  input  wire          dec_dsp_i,
  input  wire          dec_nop_i,
  output reg  [IW-1:0] id_word_o,
  output reg  [IW-1:0] ex_word_o,
  output reg  [4:0]    stage_v_o,
  output reg           slot_start_o,
  output reg  [CW-1:0] slot_cycles_o,
  output reg           ex_start_o,
  output reg  [CW-1:0] exec_cycles_o,
  output reg           exec_valid_o,
  output reg           wbd_fire_o
);

  // ****************************************
  // functions
  // ****************************************
  // saturating increment
  function [CW-1:0] sat_inc;
    input [CW-1:0] v;
    begin
      if (&v) begin
        sat_inc = v;
      end else begin
        sat_inc = v + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // write-back/DSP needed by the decoded class
  function wbd_need;
    input load;
    input dsp;
    input store;
    input nop;
    begin
      wbd_need = load | (dsp & ~store & ~nop);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [IW-1:0] fetch_word_q;
  reg          ex_ma_q;
  reg          ex_st_q;
  reg          ex_wbd_q;
  reg          ma_ma_q;
  reg          ma_wbd_q;
  reg          ma_pend_q;
  reg          if_pend_q;
  reg          wb_early_q;
  reg          seen_ex_q;
  reg [CW-1:0] slot_len_q;
  reg [CW-1:0] ex_cnt_q;

  wire         ma_done;
  wire         if_done;
  wire         ma_left;
  wire         if_left;
  wire         slot_end;
  wire         dec_wbd;
  reg          ma_pend_d;
  reg          if_pend_d;
  reg          ex_start_d;
  reg  [IW-1:0] fetched;
  localparam [CW-1:0] one_cnt = {{(CW-1){1'b0}}, `FIXED_STAGE_CYC};

  // ****************************************
  // slot timing
  // ****************************************
  // memory stages end on ack
  assign ma_done = ma_pend_q & dmem_ack_i;
  assign if_done = imem_req_o & imem_ack_i;
  assign ma_left = ma_pend_q & ~dmem_ack_i;
  assign if_left = if_pend_q & ~if_done;
  assign slot_end = ~ma_left & ~if_left;

  // no DSP for stores or nop
  assign dec_wbd = wbd_need(dec_load_i, dec_dsp_i, dec_store_i, dec_nop_i);

  // ****************************************
  // next slot decisions
  // ****************************************
  always @* begin
    ex_start_d = slot_end & stage_v_o[`STG_DECODE];
    if (slot_end) begin
      ma_pend_d = stage_v_o[`STG_EXECUTE] & ex_ma_q;
      if_pend_d = run_i;
    end else begin
      ma_pend_d = ma_left;
      if_pend_d = if_left;
    end
    if (if_done) begin
      fetched = imem_rdata_i;
    end else begin
      fetched = fetch_word_q;
    end
  end

  // ****************************************
  // memory handshakes
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ma_pend_q    <= 1'b0;
      if_pend_q    <= 1'b0;
      dmem_req_o   <= 1'b0;
      imem_req_o   <= 1'b0;
      fetch_word_q <= `WORD_RST;
    end else begin
      ma_pend_q  <= ma_pend_d;
      if_pend_q  <= if_pend_d;
      dmem_req_o <= ma_pend_d;
      imem_req_o <= if_pend_d & ~ma_pend_d;
      if (if_done) begin
        fetch_word_q <= imem_rdata_i;
      end
    end
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dmem_we_o <= 1'b0;
    end else if (slot_end) begin
      dmem_we_o <= ex_st_q;
    end
  end

  // ****************************************
  // stage registers
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_v_o <= `STG_VALID_RST;
    end else if (slot_end) begin
      stage_v_o[`STG_FETCH]   <= run_i;
      stage_v_o[`STG_DECODE]  <= stage_v_o[`STG_FETCH];
      stage_v_o[`STG_EXECUTE] <= stage_v_o[`STG_DECODE];
      stage_v_o[`STG_MEMACC]  <= stage_v_o[`STG_EXECUTE]
                                 & (ex_ma_q | ex_wbd_q);
      stage_v_o[`STG_WBDSP]   <= stage_v_o[`STG_MEMACC] & ma_wbd_q
                                 & ~wb_early_q;
    end
  end

  // ****************************************
  // pipeline payload
  // ****************************************
  // words held while slot stalls
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      id_word_o <= `WORD_RST;
      ex_word_o <= `WORD_RST;
    end else if (slot_end) begin
      id_word_o <= fetched;
      ex_word_o <= id_word_o;
    end
  end

  // ****************************************
  // decoded class per stage
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ex_ma_q  <= 1'b0;
      ex_st_q  <= 1'b0;
      ex_wbd_q <= 1'b0;
      ma_ma_q  <= 1'b0;
      ma_wbd_q <= 1'b0;
    end else if (slot_end) begin
      ex_ma_q  <= dec_ma_i;
      ex_st_q  <= dec_store_i;
      ex_wbd_q <= dec_wbd;
      ma_ma_q  <= ex_ma_q;
      ma_wbd_q <= ex_wbd_q;
    end
  end

  // ****************************************
  // write-back/DSP firing
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_early_q <= 1'b0;
      wbd_fire_o <= 1'b0;
    end else begin
      if (ma_done & ma_wbd_q & ma_ma_q & if_left) begin
        wb_early_q <= 1'b1;
        wbd_fire_o <= 1'b1;
      end else if (slot_end) begin
        wb_early_q <= 1'b0;
        wbd_fire_o <= stage_v_o[`STG_MEMACC] & ma_wbd_q & ~wb_early_q;
      end else begin
        wbd_fire_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // slot length
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_len_q    <= one_cnt;
      slot_cycles_o <= `CNT_RST;
      slot_start_o  <= 1'b0;
    end else begin
      slot_start_o <= slot_end;
      if (slot_end) begin
        slot_cycles_o <= slot_len_q;
        slot_len_q    <= one_cnt;
      end else begin
        slot_len_q <= sat_inc(slot_len_q);
      end
    end
  end

  // ****************************************
  // execution time
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ex_cnt_q      <= `CNT_RST;
      exec_cycles_o <= `CNT_RST;
      exec_valid_o  <= 1'b0;
      ex_start_o    <= 1'b0;
      seen_ex_q     <= 1'b0;
    end else begin
      ex_start_o <= ex_start_d;
      if (ex_start_d) begin
        ex_cnt_q      <= one_cnt;
        seen_ex_q     <= 1'b1;
        exec_cycles_o <= ex_cnt_q;
        exec_valid_o  <= seen_ex_q;
      end else begin
        ex_cnt_q     <= sat_inc(ex_cnt_q);
        exec_valid_o <= 1'b0;
      end
    end
  end

endmodule // pipe_slot_ctrl

`default_nettype wire

// file: core/pipe_slot_regs.vh
/*
 * Constants for the five-stage pipeline slot controller: stage bit
 * positions, reset values and fixed stage lengths.
 * Assumes it is included by its bare name from core/.
 */
`ifndef PIPE_SLOT_REGS_VH
`define PIPE_SLOT_REGS_VH

// ****************************************
// stage positions in the stage vector
// ****************************************
`define STG_FETCH      0
`define STG_DECODE     1
`define STG_EXECUTE    2
`define STG_MEMACC     3
`define STG_WBDSP      4
`define STG_COUNT      5

// ****************************************
// reset values
// ****************************************
`define STG_VALID_RST  5'h00
`define WORD_RST       16'h0000
`define CNT_RST        8'h00

// ****************************************
// fixed stage length in cycles
// ****************************************
`define FIXED_STAGE_CYC 1'h1

`endif

// file: testbench/mem_partner.sv
/* mem_partner: program and data memory with set latencies.
   assumes requests held until ack, one clock. */
`timescale 1ns/10ps
`default_nettype none
module mem_partner (
  input wire logic clock_i, rstn_i, imem_req_i, dmem_req_i,
  input wire logic [7:0] ilat_i, dlat_i,
  output logic imem_ack_o, dmem_ack_o,
  output logic [15:0] imem_rdata_o);
  logic [7:0] ic_q, dc_q;
  logic [15:0] seq_q;
  assign imem_ack_o = imem_req_i && (ic_q + 8'h01 >= ilat_i);
  assign dmem_ack_o = dmem_req_i && (dc_q + 8'h01 >= dlat_i);
  assign imem_rdata_o = imem_ack_o ? seq_q : ~seq_q;
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i) begin
      ic_q <= 8'h00;
      dc_q <= 8'h00;
      seq_q <= 16'hC000;
    end else begin
      ic_q <= (imem_req_i && !imem_ack_o) ? ic_q + 8'h01 : 8'h00;
      dc_q <= (dmem_req_i && !dmem_ack_o) ? dc_q + 8'h01 : 8'h00;
      if (imem_ack_o) seq_q <= seq_q + 16'h0001;
    end
endmodule // mem_partner
`default_nettype wire

// file: testbench/pipe_slot_ctrl_tb.sv
/* pipe_slot_ctrl_tb: slot timing per instruction class.
   assumes mem_partner answers both memory ports. */
`timescale 1ns/10ps
`default_nettype none
module pipe_slot_ctrl_tb;
  logic clock_i, rstn_i, run_i, imem_ack_i, dmem_ack_i;
  logic dec_ma_i, dec_load_i, dec_store_i, dec_dsp_i, dec_nop_i;
  logic [15:0] imem_rdata_i, id_word_o, ex_word_o;
  logic imem_req_o, dmem_req_o, dmem_we_o, slot_start_o, ex_start_o;
  logic exec_valid_o, wbd_fire_o;
  logic [4:0] stage_v_o;
  logic [7:0] slot_cycles_o, exec_cycles_o, ilat, dlat;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  pipe_slot_ctrl pipe_slot_ctrl_inst (.clock_i, .rstn_i, .run_i,
    .imem_req_o, .imem_ack_i, .imem_rdata_i, .dmem_req_o, .dmem_we_o,
    .dmem_ack_i, .dec_ma_i, .dec_load_i, .dec_store_i, .dec_dsp_i,
    .dec_nop_i, .id_word_o, .ex_word_o, .stage_v_o, .slot_start_o,
    .slot_cycles_o, .ex_start_o, .exec_cycles_o, .exec_valid_o,
    .wbd_fire_o);
  mem_partner mem_partner_inst (.clock_i, .rstn_i, .imem_req_i(imem_req_o),
    .dmem_req_i(dmem_req_o), .ilat_i(ilat), .dlat_i(dlat),
    .imem_ack_o(imem_ack_i), .dmem_ack_o(dmem_ack_i),
    .imem_rdata_o(imem_rdata_i));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // class bits: nop dsp store load ma
  task automatic restart(logic [4:0] c, logic [7:0] il, logic [7:0] dl);
    @(posedge clock_i);
    #1 rstn_i = 1'b0;
    run_i = 1'b0;
    {dec_nop_i, dec_dsp_i, dec_store_i, dec_load_i, dec_ma_i} = c;
    ilat = il;
    dlat = dl;
    repeat (2) @(posedge clock_i);
    #1 chk("reset occupancy", 16'(stage_v_o), 16'h0000);
    rstn_i = 1'b1;
  endtask
  task automatic run_mix(logic [4:0] c, logic [7:0] il, logic [7:0] dl,
                         output logic [7:0] ex, output logic wb, we);
    int n;
    restart(c, il, dl);
    {wb, we, ex, n} = '0;
    run_i = 1'b1;
    while (n < 12) begin
      @(posedge clock_i);
      #1 if (ex_start_o === 1'b1 && n == 0)
        chk("first word", ex_word_o, 16'hC000);
      if (ex_start_o === 1'b1) n++;
      if (exec_valid_o === 1'b1) ex = exec_cycles_o;
      wb |= wbd_fire_o === 1'b1;
      we |= dmem_req_o === 1'b1 && dmem_we_o === 1'b1;
    end
  endtask
  task automatic t_fetch;
    logic [7:0] ex;
    logic wb, we;
    for (int l = 1; l < 4; l++) begin
      run_mix(5'h00, l[7:0], 8'h01, ex, wb, we);
      chk("fetch exec", 16'(ex), 16'(l[7:0]));
      chk("alu wb", 16'(wb), 16'h0000);
    end
  endtask
  task automatic t_load;
    logic [7:0] ex;
    logic wb, we;
    run_mix(5'h03, 8'h02, 8'h03, ex, wb, we);
    chk("load exec", 16'(ex), 16'h0005);
    chk("load wb", 16'(wb), 16'h0001);
    chk("load we", 16'(we), 16'h0000);
  endtask
  task automatic t_store;
    logic [7:0] ex;
    logic wb, we;
    run_mix(5'h0D, 8'h01, 8'h02, ex, wb, we);
    chk("store exec", 16'(ex), 16'h0003);
    chk("store wb", 16'(wb), 16'h0000);
    chk("store we", 16'(we), 16'h0001);
  endtask
  task automatic t_dsp_nop;
    logic [7:0] ex;
    logic wb, we;
    run_mix(5'h08, 8'h02, 8'h01, ex, wb, we);
    chk("dsp exec", 16'(ex), 16'h0002);
    chk("dsp wb", 16'(wb), 16'h0001);
    run_mix(5'h18, 8'h01, 8'h01, ex, wb, we);
    chk("nop exec", 16'(ex), 16'h0001);
    chk("nop wb", 16'(wb), 16'h0000);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {rstn_i, run_i, dec_ma_i, dec_load_i, dec_store_i} = '0;
    {dec_dsp_i, dec_nop_i, ilat, dlat} = '0;
    t_fetch();
    t_load();
    t_store();
    t_dsp_nop();
    complete_run();
  end
endmodule // pipe_slot_ctrl_tb
`default_nettype wire

// file: testbench/pipe_slot_sva.sv
/* pipe_slot_sva: port checks for pipe_slot_ctrl.
   assumes one clock and an active-low async reset. */
`timescale 1ns/10ps
`default_nettype none
module pipe_slot_sva #(parameter IW = 16, parameter CW = 8) (
  input wire logic clock_i, rstn_i, imem_req_o, imem_ack_i,
  input wire logic dmem_req_o, dmem_we_o, dmem_ack_i,
  input wire logic slot_start_o, ex_start_o, exec_valid_o,
  input wire logic [IW-1:0] id_word_o, ex_word_o,
  input wire logic [4:0] stage_v_o,
  input wire logic [CW-1:0] slot_cycles_o, exec_cycles_o);
  localparam [CW-1:0] ONE = 1;
  logic [CW-1:0] ex_n_q, sl_n_q;
  logic sl_seen_q;
  // cycles since the last execute and slot start
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i) begin
      ex_n_q <= '0;
      sl_n_q <= '0;
      sl_seen_q <= 1'b0;
    end else begin
      ex_n_q <= ex_start_o ? ONE : ex_n_q + ONE;
      sl_n_q <= slot_start_o ? ONE : sl_n_q + ONE;
      sl_seen_q <= sl_seen_q | slot_start_o;
    end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_dwait; dmem_req_o && !dmem_ack_i; endsequence
  sequence s_ddone; dmem_req_o && dmem_ack_i; endsequence
  property p_excl; !(imem_req_o && dmem_req_o); endproperty
  a_excl: assert property (p_excl)
    else $error("fetch and data access overlap");
  property p_ihold; imem_req_o && !imem_ack_i |=> imem_req_o; endproperty
  a_ihold: assert property (p_ihold)
    else $error("fetch request dropped early");
  property p_dhold; s_dwait |=> dmem_req_o && $stable(dmem_we_o); endproperty
  a_dhold: assert property (p_dhold)
    else $error("data request not held");
  property p_ddrop; s_ddone |=> !dmem_req_o || slot_start_o; endproperty
  a_ddrop: assert property (p_ddrop)
    else $error("data request after ack");
  property p_whold;
    !slot_start_o |-> $stable(id_word_o) && $stable(ex_word_o);
  endproperty
  a_whold: assert property (p_whold)
    else $error("stage word changed inside slot");
  property p_exec;
    ex_start_o && exec_valid_o |-> exec_cycles_o == ex_n_q;
  endproperty
  a_exec: assert property (p_exec)
    else $error("execution time wrong");
  property p_slen; slot_start_o && sl_seen_q |-> slot_cycles_o == sl_n_q;
  endproperty
  a_slen: assert property (p_slen)
    else $error("slot length wrong");
  property p_exslot; ex_start_o |-> slot_start_o && stage_v_o[2]; endproperty
  a_exslot: assert property (p_exslot)
    else $error("execute start outside slot start");
endmodule // pipe_slot_sva
bind pipe_slot_ctrl pipe_slot_sva #(.IW(IW), .CW(CW)) pipe_slot_sva_inst (
  .clock_i, .rstn_i, .imem_req_o, .imem_ack_i, .dmem_req_o, .dmem_we_o,
  .dmem_ack_i, .slot_start_o, .ex_start_o, .exec_valid_o, .id_word_o,
  .ex_word_o, .stage_v_o, .slot_cycles_o, .exec_cycles_o);
`default_nettype wire
